// ===== pmc_regs.sv
// power management capability register bank of a bus bridge, apb slave
// assumes strap and mode pins are asynchronous; secondary clocks are gated
// downstream from pclk by sec_clk_run

module pmc_regs
	import pmc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic first_mode_strap,
	input wire logic second_mode_strap,
	input wire logic bus_clock_control_strap,
	input wire logic compact_mode,
	output logic [1:0] power_state,
	output logic internal_reset,
	output logic sec_clk_run
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic ms0_s;
	logic ms1_s;
	logic bcc_s;
	logic cpci_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
		end else begin
			pin_meta_r <= {compact_mode, bus_clock_control_strap, second_mode_strap,
				first_mode_strap};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign ms0_s = pin_sync_r[0];
	assign ms1_s = pin_sync_r[1];
	assign bcc_s = pin_sync_r[2];
	assign cpci_s = pin_sync_r[3];

	// ----------------------------------------------------------------
	// read values
	// ----------------------------------------------------------------
	logic [7:0] link_val;
	logic [15:0] feature_val;
	logic [15:0] control_val;
	logic [7:0] policy_val;
	logic [1:0] state_r;

	always_comb begin
		link_val = cpci_s ? PMC_LINK_COMPACT : PMC_LINK_OTHER;
		feature_val = 16'h0000;
		feature_val[PMC_FEAT_D2_BIT] = ~ms0_s;
		feature_val[PMC_FEAT_D1_BIT] = ~ms0_s;
		feature_val[2:0] = ms0_s ? PMC_REV_STRAP_HIGH : PMC_REV_STRAP_LOW;
		control_val = {14'h0000, state_r};
		policy_val = 8'h00;
		policy_val[PMC_POL_ENABLE_BIT] = bcc_s;
		policy_val[PMC_POL_STOP_BIT] = bcc_s;
	end

	// ----------------------------------------------------------------
	// apb slave: answers in the first access cycle
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic hit_ctl;
	logic ready_r;
	logic ready_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic err_r;
	logic err_nxt;

	assign setup = psel && !penable;
	assign access = psel && penable && ready_r;
	assign hit_ctl = paddr[11:2] == PMC_IDX_CONTROL && paddr[1:0] == 2'h0;

	always_comb begin
		ready_nxt = setup;
		rdata_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		if (setup && paddr[1:0] == 2'h0) begin
			unique case (paddr[11:2])
				PMC_IDX_TAG: rdata_nxt = {24'h000000, PMC_TAG_VALUE};
				PMC_IDX_LINK: rdata_nxt = {24'h000000, link_val};
				PMC_IDX_FEATURE: rdata_nxt = {16'h0000, feature_val};
				PMC_IDX_CONTROL: rdata_nxt = {16'h0000, control_val};
				PMC_IDX_POLICY: rdata_nxt = {24'h000000, policy_val};
				PMC_IDX_REPORT: rdata_nxt = {24'h000000, PMC_REPORT_VALUE};
				default: err_nxt = 1'b1;
			endcase
		end else if (setup) begin
			err_nxt = 1'b1;
		end
		if (pwrite) begin
			rdata_nxt = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			ready_r <= ready_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign pready = ready_r;
	assign prdata = rdata_r;
	assign pslverr = err_r;

	// ----------------------------------------------------------------
	// power state, internal reset, secondary clock gate
	// ----------------------------------------------------------------
	logic state_we;
	logic [1:0] state_nxt;
	logic ireset_r;
	logic ireset_nxt;
	logic clk_run_r;
	logic clk_run_nxt;

	// only bits 1..0 of the control word take a write; all else ignored
	assign state_we = access && pwrite && hit_ctl && pstrb[0] && !ms1_s;

	always_comb begin
		state_nxt = state_r;
		ireset_nxt = 1'b0;
		if (state_we) begin
			state_nxt = pwdata[1:0];
			// internal reset does not touch state_r
			ireset_nxt = state_r == PMC_D3HOT && pwdata[1:0] == PMC_D0;
		end
		clk_run_nxt = !(bcc_s && state_nxt == PMC_D3HOT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= PMC_STATE_RESET;
			ireset_r <= 1'b0;
			clk_run_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			ireset_r <= ireset_nxt;
			clk_run_r <= clk_run_nxt;
		end
	end

	assign power_state = state_r;
	assign internal_reset = ireset_r;
	assign sec_clk_run = clk_run_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic rd_done;
	assign rd_done = access && !pwrite && paddr[1:0] == 2'h0;

	property p_tag_read;
		@(posedge pclk) disable iff (!presetn)
		rd_done && paddr[11:2] == PMC_IDX_TAG |-> prdata == 32'h0000_0001;
	endproperty
	a_tag_read: assert property (p_tag_read) else $error("tag byte not 01h");

	property p_link_read;
		@(posedge pclk) disable iff (!presetn)
		rd_done && paddr[11:2] == PMC_IDX_LINK |->
			prdata == ($past(cpci_s) ? 32'h0000_00e4 : 32'h0000_0000);
	endproperty
	a_link_read: assert property (p_link_read) else $error("link byte wrong");

	property p_feature_read;
		@(posedge pclk) disable iff (!presetn)
		rd_done && paddr[11:2] == PMC_IDX_FEATURE |->
			prdata == ($past(ms0_s) ? 32'h0000_0001 : 32'h0000_0602);
	endproperty
	a_feature_read: assert property (p_feature_read) else $error("feature word wrong");

	property p_control_read;
		@(posedge pclk) disable iff (!presetn)
		rd_done && hit_ctl |-> prdata == {30'h0, $past(state_r)};
	endproperty
	a_control_read: assert property (p_control_read) else $error("control word wrong");

	property p_policy_read;
		@(posedge pclk) disable iff (!presetn)
		rd_done && paddr[11:2] == PMC_IDX_POLICY |->
			prdata == ($past(bcc_s) ? 32'h0000_00c0 : 32'h0000_0000);
	endproperty
	a_policy_read: assert property (p_policy_read) else $error("bridge byte wrong");

	property p_state_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && hit_ctl && pstrb[0] && !ms1_s |=> state_r == $past(pwdata[1:0]);
	endproperty
	a_state_write: assert property (p_state_write) else $error("state not written");

	property p_state_locked;
		@(posedge pclk) disable iff (!presetn)
		ms1_s && $past(ms1_s) |-> $stable(state_r);
	endproperty
	a_state_locked: assert property (p_state_locked) else $error("state moved");

	property p_ireset;
		@(posedge pclk) disable iff (!presetn)
		state_r == PMC_D3HOT ##1 state_r == PMC_D0 |-> internal_reset ##1 !internal_reset;
	endproperty
	a_ireset: assert property (p_ireset) else $error("no internal reset pulse");

	property p_clk_stop;
		@(posedge pclk) disable iff (!presetn)
		state_r == PMC_D3HOT && $past(bcc_s) |-> !sec_clk_run;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clocks run in d3hot");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		access && paddr[1:0] != 2'h0 |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unaligned not refused");

	// ----------------------------------------------------------------
	// field assertions: fixed and strap bits of data byte, feature word, control word and bridge byte; reset, clock and write checks
	// ----------------------------------------------------------------
	logic rd_feat;
	logic rd_ctl;
	logic rd_pol;
	logic wr_any;
	assign rd_feat = rd_done && paddr[11:2] == PMC_IDX_FEATURE;
	assign rd_ctl = rd_done && hit_ctl;
	assign rd_pol = rd_done && paddr[11:2] == PMC_IDX_POLICY;
	assign wr_any = access && pwrite;

	property p_report_read;
		@(posedge pclk) disable iff (!presetn)
		rd_done && paddr[11:2] == PMC_IDX_REPORT |->
			prdata == 32'h0000_0000;
	endproperty
	a_report_read: assert property (p_report_read) else $error("data byte not 00h");

	property p_wake_support;
		@(posedge pclk) disable iff (!presetn)
		rd_feat |->
			prdata[15:11] == 5'h00;
	endproperty
	a_wake_support: assert property (p_wake_support) else $error("wake field set");

	property p_feature_d2;
		@(posedge pclk) disable iff (!presetn)
		rd_feat |->
			prdata[PMC_FEAT_D2_BIT] == !$past(ms0_s);
	endproperty
	a_feature_d2: assert property (p_feature_d2) else $error("d2 bit wrong");

	property p_feature_d1;
		@(posedge pclk) disable iff (!presetn)
		rd_feat |->
			prdata[PMC_FEAT_D1_BIT] == !$past(ms0_s);
	endproperty
	a_feature_d1: assert property (p_feature_d1) else $error("d1 bit wrong");

	property p_feature_resv;
		@(posedge pclk) disable iff (!presetn)
		rd_feat |->
			prdata[8:6] == 3'h0;
	endproperty
	a_feature_resv: assert property (p_feature_resv) else $error("feature bits 8..6 set");

	property p_feature_misc;
		@(posedge pclk) disable iff (!presetn)
		rd_feat |->
			prdata[5:3] == 3'h0;
	endproperty
	a_feature_misc: assert property (p_feature_misc) else $error("feature bits 5..3 set");

	property p_feature_rev;
		@(posedge pclk) disable iff (!presetn)
		rd_feat |->
			prdata[2:0] == ($past(ms0_s) ? PMC_REV_STRAP_HIGH : PMC_REV_STRAP_LOW);
	endproperty
	a_feature_rev: assert property (p_feature_rev) else $error("revision wrong");

	property p_ctl_wake;
		@(posedge pclk) disable iff (!presetn)
		rd_ctl |->
			prdata[15] == 1'b0 && prdata[8] == 1'b0;
	endproperty
	a_ctl_wake: assert property (p_ctl_wake) else $error("wake bits set");

	property p_ctl_data;
		@(posedge pclk) disable iff (!presetn)
		rd_ctl |->
			prdata[14:9] == 6'h00;
	endproperty
	a_ctl_data: assert property (p_ctl_data) else $error("data scale or select set");

	property p_ctl_resv;
		@(posedge pclk) disable iff (!presetn)
		rd_ctl |->
			prdata[7:2] == 6'h00;
	endproperty
	a_ctl_resv: assert property (p_ctl_resv) else $error("control bits 7..2 set");

	property p_pol_enable;
		@(posedge pclk) disable iff (!presetn)
		rd_pol |->
			prdata[PMC_POL_ENABLE_BIT] == $past(bcc_s);
	endproperty
	a_pol_enable: assert property (p_pol_enable) else $error("enable bit wrong");

	property p_pol_stop;
		@(posedge pclk) disable iff (!presetn)
		rd_pol |->
			prdata[PMC_POL_STOP_BIT] == $past(bcc_s);
	endproperty
	a_pol_stop: assert property (p_pol_stop) else $error("stop bit wrong");

	property p_pol_resv;
		@(posedge pclk) disable iff (!presetn)
		rd_pol |->
			prdata[5:0] == 6'h00;
	endproperty
	a_pol_resv: assert property (p_pol_resv) else $error("bridge bits 5..0 set");

	property p_ireset_keep;
		@(posedge pclk) disable iff (!presetn)
		internal_reset |->
			state_r == PMC_D0 ##1 $stable(state_r);
	endproperty
	a_ireset_keep: assert property (p_ireset_keep) else $error("state moved by reset");

	property p_ireset_cause;
		@(posedge pclk) disable iff (!presetn)
		internal_reset |->
			$past(state_r) == PMC_D3HOT;
	endproperty
	a_ireset_cause: assert property (p_ireset_cause) else $error("stray internal reset");

	property p_clk_run;
		@(posedge pclk) disable iff (!presetn)
		state_r != PMC_D3HOT |->
			sec_clk_run;
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("clocks stopped outside d3hot");

	property p_clk_free;
		@(posedge pclk) disable iff (!presetn)
		!$past(bcc_s) |->
			sec_clk_run;
	endproperty
	a_clk_free: assert property (p_clk_free) else $error("clocks stopped with strap low");

	property p_ro_write;
		@(posedge pclk) disable iff (!presetn)
		wr_any && !hit_ctl |=>
			$stable(state_r);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("state moved by other write");

	property p_strobe_off;
		@(posedge pclk) disable iff (!presetn)
		wr_any && hit_ctl && !pstrb[0] |=>
			$stable(state_r);
	endproperty
	a_strobe_off: assert property (p_strobe_off) else $error("state moved without strobe");

endmodule : pmc_regs

// ===== pmc_pkg.sv
// constants of the power management capability register bank
// assumes an apb slave with 32-bit data and a 12-bit byte address
//
// How it works
// - capability identifier byte at index dc reads fixed 01h.
// - next-item link reads e4h in compact mode, otherwise 00h.
// - wake-event support field, capability word bits 15..11, reads zero.
// - capability bit 10 reads inverse of first mode strap (d2 support).
// - capability bit 9 reads inverse of first mode strap (d1 support).
// - capability word bits 8..6 read zero.
// - capability word bits 5, 4 and 3 read zero.
// - revision bits 2..0 read 001 with first strap high, 010 low.
// - power states supported only while second mode strap is low.
// - writable two-bit power state at control word bits 1..0.
// - d3hot to d0 raises internal reset; control word keeps its value.
// - wake status bit 15 and wake enable bit 8 read zero.
// - data scale bits 14..13 and data select 12..9 read zero.
// - control word bits 7..2 read zero.
// - bridge byte bit 7 mirrors the bus clock control strap.
// - bridge byte bit 6 mirrors strap; when set, secondary clocks stop in d3hot.
// - secondary clocks are derived from the primary clock.
// - bridge byte bits 5..0 read zero.
// - data byte at index e3 reads 00h.

package pmc_pkg;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [9:0] PMC_IDX_TAG = 10'h0dc;
	localparam logic [9:0] PMC_IDX_LINK = 10'h0dd;
	localparam logic [9:0] PMC_IDX_FEATURE = 10'h0de;
	localparam logic [9:0] PMC_IDX_CONTROL = 10'h0e0;
	localparam logic [9:0] PMC_IDX_POLICY = 10'h0e2;
	localparam logic [9:0] PMC_IDX_REPORT = 10'h0e3;

	// ----------------------------------------------------------------
	// fixed values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] PMC_TAG_VALUE = 8'h01;
	localparam logic [7:0] PMC_LINK_COMPACT = 8'he4;
	localparam logic [7:0] PMC_LINK_OTHER = 8'h00;
	localparam logic [7:0] PMC_REPORT_VALUE = 8'h00;
	localparam logic [2:0] PMC_REV_STRAP_HIGH = 3'h1;
	localparam logic [2:0] PMC_REV_STRAP_LOW = 3'h2;
	localparam int PMC_FEAT_D2_BIT = 10;
	localparam int PMC_FEAT_D1_BIT = 9;
	localparam int PMC_POL_ENABLE_BIT = 7;
	localparam int PMC_POL_STOP_BIT = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PMC_STATE_RESET = 2'h0;

	typedef enum logic [1:0] {
		PMC_D0 = 2'h0,
		PMC_D1 = 2'h1,
		PMC_D2 = 2'h2,
		PMC_D3HOT = 2'h3
	} pmc_state_e;

endpackage : pmc_pkg

// ===== pmc_tb.sv
// self-checking bench for the power management capability register bank
// assumes pmc_regs as apb slave on pclk with async active-low presetn

module tb
	import pmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [11:0] A_TAG = {PMC_IDX_TAG, 2'b00};
	localparam logic [11:0] A_LINK = {PMC_IDX_LINK, 2'b00};
	localparam logic [11:0] A_FEAT = {PMC_IDX_FEATURE, 2'b00};
	localparam logic [11:0] A_CTL = {PMC_IDX_CONTROL, 2'b00};
	localparam logic [11:0] A_POL = {PMC_IDX_POLICY, 2'b00};
	localparam logic [11:0] A_REP = {PMC_IDX_REPORT, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic first_mode_strap, second_mode_strap, bus_clock_control_strap, compact_mode;
	logic [1:0] power_state;
	logic internal_reset, sec_clk_run;
	int error_cnt, samples_checked, cycles, pulses;

	pmc_regs u_pmc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .first_mode_strap(first_mode_strap),
		.second_mode_strap(second_mode_strap), .bus_clock_control_strap(bus_clock_control_strap),
		.compact_mode(compact_mode), .power_state(power_state),
		.internal_reset(internal_reset), .sec_clk_run(sec_clk_run));

	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end

	// counts internal reset pulses and cuts a hang short
	always @(posedge pclk) begin
		cycles++;
		if (internal_reset === 1'b1)
			pulses++;
		if (cycles == 5000) begin
			error_cnt++;
			$display("Error t=%0t limit=%h cycles=%h", $time, 32'd5000, cycles);
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task chk(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		pwrite <= 0;
	endtask : apb

	task print_verdict();
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_fixed;
		apb(0, A_CTL, 0); chk(32'h0, rd);
		apb(0, A_TAG, 0); chk(32'h01, rd);
		apb(0, A_REP, 0); chk(32'h00, rd);
		apb(1, A_TAG, 32'hff);
		apb(1, A_FEAT, 32'hffff);
		apb(1, A_REP, 32'hff);
		apb(0, A_TAG, 0); chk(32'h01, rd);
		apb(0, A_REP, 0); chk(32'h00, rd);
		apb(0, 12'h000, 0); chk(32'h1, {31'h0, er});
		chk(32'h0, rd);
		$display("t_fixed done");
	endtask : t_fixed

	task t_straps;
		for (int i = 0; i < 2; i++) begin
			first_mode_strap <= i[0];
			bus_clock_control_strap <= i[0];
			compact_mode <= i[0];
			repeat (4) @(posedge pclk);
			apb(0, A_FEAT, 0); chk(i ? 32'h0001 : 32'h0602, rd);
			apb(0, A_POL, 0); chk({24'h0, i[0], i[0], 6'h00}, rd);
			apb(0, A_LINK, 0); chk(i ? 32'he4 : 32'h00, rd);
		end
		$display("t_straps done");
	endtask : t_straps

	task automatic t_states;
		int p0 = pulses;
		for (int s = 0; s < 4; s++) begin
			apb(1, A_CTL, 32'hffff_fffc | s);
			@(negedge pclk);
			chk(s, {30'h0, power_state});
			chk(s != 3, {31'h0, sec_clk_run});
			apb(0, A_CTL, 0); chk(s, rd);
		end
		chk(p0, pulses);
		apb(1, A_CTL, 0);
		@(negedge pclk);
		chk(32'h1, {31'h0, internal_reset});
		chk(32'h0, {30'h0, power_state});
		chk(32'h1, {31'h0, sec_clk_run});
		@(negedge pclk);
		chk(32'h0, {31'h0, internal_reset});
		chk(p0 + 1, pulses);
		apb(0, A_CTL, 0); chk(32'h0, rd);
		pstrb <= 4'h0;
		apb(1, A_CTL, 32'h1);
		pstrb <= 4'hf;
		apb(0, A_CTL, 0); chk(32'h0, rd);
		bus_clock_control_strap <= 0;
		repeat (4) @(posedge pclk);
		apb(1, A_CTL, 32'h3);
		@(negedge pclk);
		chk(32'h1, {31'h0, sec_clk_run});
		apb(1, A_CTL, 0);
		$display("t_states done");
	endtask : t_states

	task t_no_pm;
		second_mode_strap <= 1;
		repeat (4) @(posedge pclk);
		apb(1, A_CTL, 32'h2);
		apb(0, A_CTL, 0); chk(32'h0, rd);
		chk(32'h0, {30'h0, power_state});
		second_mode_strap <= 0;
		$display("t_no_pm done");
	endtask : t_no_pm

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{first_mode_strap, second_mode_strap, bus_clock_control_strap, compact_mode} = '0;
		pstrb = 4'hf;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		t_fixed();
		t_straps();
		t_states();
		t_no_pm();
		print_verdict();
	end

endmodule : tb
